// ### hw/status_pkg.sv
package status_pkg;

  // ****************************************************************
  // register map (printed status offsets are register indices; control offsets are byte addresses)
  // ****************************************************************
  localparam logic [7:0]  ALARM_STATUS_IDX   = 8'h1e;
  localparam logic [7:0]  GENERAL_STATUS_IDX = 8'h1f;
  localparam logic [11:0] ALARM_STATUS_ADDR  = {2'h0, ALARM_STATUS_IDX, 2'h0};
  localparam logic [11:0] GENERAL_STATUS_ADDR = {2'h0, GENERAL_STATUS_IDX, 2'h0};
  localparam logic [11:0] CONV_CTRL_ADDR     = 12'h100;
  localparam logic [11:0] CONFIG_EVT_ADDR    = 12'h104;
  localparam logic [15:0] STATUS_RESET       = 16'h0000;

  // ****************************************************************
  // general status fields
  // ****************************************************************
  localparam int GS_GLOBAL_DATA  = 15;
  localparam int GS_CONV_IDLE    = 14;
  localparam int GS_DAV_HI       = 13;
  localparam int GS_DAV_LO       = 8;
  localparam int GS_STANDBY_B    = 3;
  localparam int GS_STANDBY_A    = 2;
  localparam int GS_AMP_ENABLE   = 1;
  localparam int GS_GLOBAL_ALARM = 0;
  localparam int NUM_DAV         = 6;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CC_POWER_BIT    = 0;
  localparam int CC_CHSEL_LO     = 8;
  localparam int CC_CHSEL_W      = 8;
  localparam int CC_TRIGGER_BIT  = 16;
  localparam int CE_HALT_BIT     = 0;
  localparam int CE_CLEAR_DAV_BIT = 1;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int UPDATE_TIME_NS  = 1000;
  localparam int UPDATE_CYCLES   = (UPDATE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    CONV_OFF     = 2'b00,
    CONV_READY   = 2'b01,
    CONV_RUNNING = 2'b11,
    CONV_UPDATE  = 2'b10
  } conv_state_t;

endpackage

// ### hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser, one per bit
module pin_sync
  import status_pkg::*;
#(
  parameter int W = 3
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sync_out = s_q.sync;

endmodule
`default_nettype wire

// ### hw/alarm_window.sv
`timescale 1ns/1ps
`default_nettype none
// out-of-window compare for one monitored channel
module alarm_window
  import status_pkg::*;
#(
  parameter int DW = 12
)(
  input  wire logic [DW-1:0] sample,
  input  wire logic [DW-1:0] low_thresh,
  input  wire logic [DW-1:0] high_thresh,
  output logic               outside
);

  assign outside = (sample < low_thresh) || (sample > high_thresh);

endmodule
`default_nettype wire

// ### hw/device_status_flags.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module device_status_flags
  import status_pkg::*;
#(
  parameter int DW            = 12,
  parameter int UPDATE_CYC    = UPDATE_CYCLES
)(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          closed_loop,
  input  wire logic [DW-1:0] chan_a_adc,
  input  wire logic [DW-1:0] chan_b_adc,
  input  wire logic [DW-1:0] chan_a_cs,
  input  wire logic [DW-1:0] chan_b_cs,
  input  wire logic [DW-1:0] alarm_low_thresh,
  input  wire logic [DW-1:0] alarm_high_thresh,
  input  wire logic [13:0]   upper_alarms,
  input  wire logic          conv_done,
  input  wire logic [5:0]    dav_set,
  input  wire logic          standby_pin_a,
  input  wire logic          standby_pin_b,
  input  wire logic          amp_enable_pin_n,
  output logic               conv_trigger,
  output logic               conv_idle
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0]  alarm_status;
    logic         global_alarm_flag;
    logic [5:0]   dav;
    conv_state_t  conv;
    logic [15:0]  upd_cnt;
    logic         powered;
    logic [7:0]   chan_sel;
    logic         trigger;
    logic [31:0]  rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [2:0]  pins_sync;
  logic        channel_a_monitor_alarm;
  logic        channel_b_monitor_alarm;
  logic        a_adc_out;
  logic        b_adc_out;
  logic        a_cs_out;
  logic        b_cs_out;
  logic        standby_pin_a_state;
  logic        standby_pin_b_state;
  logic        amp_enable_pin_state;
  logic [15:0] general_status;
  logic        wr_en;
  logic        rd_en;
  logic        new_alarm;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  // ****************************************************************
  // pins and window compare
  // ****************************************************************
  pin_sync #(.W(3)) u_pins (
    .pclk     (pclk),
    .presetn  (presetn),
    // amp pin inverted ahead of sync so the reset value reads as off
    .async_in ({~amp_enable_pin_n, standby_pin_b, standby_pin_a}),
    .sync_out (pins_sync)
  );

  alarm_window #(.DW(DW)) u_win_a_adc (
    .sample(chan_a_adc), .low_thresh(alarm_low_thresh),
    .high_thresh(alarm_high_thresh), .outside(a_adc_out));
  alarm_window #(.DW(DW)) u_win_b_adc (
    .sample(chan_b_adc), .low_thresh(alarm_low_thresh),
    .high_thresh(alarm_high_thresh), .outside(b_adc_out));
  alarm_window #(.DW(DW)) u_win_a_cs (
    .sample(chan_a_cs), .low_thresh(alarm_low_thresh),
    .high_thresh(alarm_high_thresh), .outside(a_cs_out));
  alarm_window #(.DW(DW)) u_win_b_cs (
    .sample(chan_b_cs), .low_thresh(alarm_low_thresh),
    .high_thresh(alarm_high_thresh), .outside(b_cs_out));

  assign channel_a_monitor_alarm = closed_loop ? a_adc_out : a_cs_out;
  assign channel_b_monitor_alarm = closed_loop ? b_adc_out : b_cs_out;

  assign standby_pin_a_state  = pins_sync[0];
  assign standby_pin_b_state  = pins_sync[1];
  assign amp_enable_pin_state = pins_sync[2];

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign new_alarm = |{upper_alarms, channel_b_monitor_alarm, channel_a_monitor_alarm};

  // ****************************************************************
  // general status word
  // ****************************************************************
  always_comb
  begin
    general_status                  = STATUS_RESET;
    general_status[GS_GLOBAL_DATA]  = |s_q.dav;
    general_status[GS_CONV_IDLE]    = (s_q.conv == CONV_READY);
    general_status[GS_DAV_HI:GS_DAV_LO] = s_q.dav;
    general_status[GS_STANDBY_B]    = standby_pin_b_state;
    general_status[GS_STANDBY_A]    = standby_pin_a_state;
    general_status[GS_AMP_ENABLE]   = amp_enable_pin_state;
    general_status[GS_GLOBAL_ALARM] = s_q.global_alarm_flag;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_d         = s_q;
    s_d.trigger = 1'b0;
    s_d.alarm_status = {upper_alarms, channel_b_monitor_alarm,
                        channel_a_monitor_alarm};
    // sticky dav flags, set wins over clear
    if (wr_en && addr_hit(paddr, CONFIG_EVT_ADDR) && pstrb[0] && pwdata[CE_CLEAR_DAV_BIT])
      s_d.dav = '0;
    s_d.dav = s_d.dav | dav_set;
    // global alarm sticky; new alarm in read cycle wins
    if (rd_en && addr_hit(paddr, ALARM_STATUS_ADDR))
      s_d.global_alarm_flag = 1'b0;
    if (new_alarm)
      s_d.global_alarm_flag = 1'b1;
    if (wr_en && addr_hit(paddr, CONV_CTRL_ADDR))
    begin
      if (pstrb[0])
        s_d.powered = pwdata[CC_POWER_BIT];
      if (pstrb[1])
        s_d.chan_sel = pwdata[CC_CHSEL_LO +: CC_CHSEL_W];
    end
    case (s_q.conv)
      CONV_OFF:
      begin
        if (s_q.powered && (s_q.chan_sel != '0))
          s_d.conv = CONV_READY;
      end
      CONV_READY:
      begin
        if (!s_q.powered || s_q.chan_sel == '0)
          s_d.conv = CONV_OFF;
        else if (wr_en && addr_hit(paddr, CONV_CTRL_ADDR) && pstrb[2]
                 && pwdata[CC_TRIGGER_BIT])
        begin
          s_d.conv    = CONV_RUNNING;
          s_d.trigger = 1'b1;
        end
      end
      CONV_RUNNING:
      begin
        if (conv_done)
          s_d.conv = CONV_OFF;
      end
      CONV_UPDATE:
      begin
        if (s_q.upd_cnt != '0)
          s_d.upd_cnt = s_q.upd_cnt - 16'h0001;
        else
          s_d.conv = CONV_OFF;
      end
      default:
        s_d.conv = CONV_OFF;
    endcase
    // halting write overrides, restarts the update wait, unless it just triggered
    if (!s_d.trigger && wr_en
        && ((addr_hit(paddr, CONFIG_EVT_ADDR) && pstrb[0] && pwdata[CE_HALT_BIT])
            || addr_hit(paddr, CONV_CTRL_ADDR)))
    begin
      s_d.conv    = CONV_UPDATE;
      s_d.upd_cnt = 16'(UPDATE_CYC - 1);
      s_d.trigger = 1'b0;
    end
    // read data; writes to status offsets fall through untouched
    s_d.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      if (addr_hit(paddr, ALARM_STATUS_ADDR))
        s_d.rdata = {16'h0000, s_q.alarm_status};
      else if (addr_hit(paddr, GENERAL_STATUS_ADDR))
        s_d.rdata = {16'h0000, general_status};
      else if (addr_hit(paddr, CONV_CTRL_ADDR))
        s_d.rdata = {15'h0000, 1'b0, s_q.chan_sel, 7'h00, s_q.powered};
    end
    else
      s_d.rdata = s_q.rdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q      <= '0;
      s_q.conv <= CONV_OFF;
    end
    else
      s_q <= s_d;
  end

  assign prdata       = s_q.rdata;
  assign pready       = 1'b1;
  assign pslverr      = 1'b0;
  assign conv_trigger = s_q.trigger;
  assign conv_idle    = general_status[GS_CONV_IDLE];

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_idle_off_unpowered;
    @(posedge pclk) disable iff (!presetn)
    (!s_q.powered) |-> ##1 !conv_idle;
  endproperty
  a_idle_off_unpowered: assert property (p_idle_off_unpowered)
    else $error("idle set while unpowered");

  property p_halt_clears_idle;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && addr_hit(paddr, CONV_CTRL_ADDR)) |=> !conv_idle [*2];
  endproperty
  a_halt_clears_idle: assert property (p_halt_clears_idle)
    else $error("idle not held low after halting write");

  property p_run_not_idle;
    @(posedge pclk) disable iff (!presetn)
    conv_trigger |-> !conv_idle;
  endproperty
  a_run_not_idle: assert property (p_run_not_idle)
    else $error("idle high during conversion");

  property p_global_alarm_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
    (s_q.global_alarm_flag && !(rd_en && addr_hit(paddr, ALARM_STATUS_ADDR)))
      |=> s_q.global_alarm_flag;
  endproperty
  a_global_alarm_flag_sticky: assert property (p_global_alarm_flag_sticky)
    else $error("global alarm dropped without read");

  property p_global_alarm_flag_set;
    @(posedge pclk) disable iff (!presetn)
    (|s_q.alarm_status) |-> s_q.global_alarm_flag;
  endproperty
  a_global_alarm_flag_set: assert property (p_global_alarm_flag_set)
    else $error("alarm present but global alarm clear");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
    general_status[7:4] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits non-zero");

  property p_global_new_data_flag_or;
    @(posedge pclk) disable iff (!presetn)
    (|dav_set) |=> general_status[GS_GLOBAL_DATA];
  endproperty
  a_global_new_data_flag_or: assert property (p_global_new_data_flag_or)
    else $error("new data flag missed");

  property p_amp_pin;
    @(posedge pclk) disable iff (!presetn)
    $fell(amp_enable_pin_n) |-> ##2 general_status[GS_AMP_ENABLE] [*1];
  endproperty
  a_amp_pin: assert property (p_amp_pin)
    else $error("amp enable status did not follow pin");

  property p_global_alarm_flag_clear_on_read;
    @(posedge pclk) disable iff (!presetn)
    (rd_en && addr_hit(paddr, ALARM_STATUS_ADDR) && !new_alarm) |=> !s_q.global_alarm_flag;
  endproperty
  a_global_alarm_flag_clear_on_read: assert property (p_global_alarm_flag_clear_on_read)
    else $error("global alarm not cleared by alarm status read");

  property p_read_keeps_dav;
    @(posedge pclk) disable iff (!presetn)
    (rd_en && (dav_set == 6'h00)) |=> $stable(s_q.dav);
  endproperty
  a_read_keeps_dav: assert property (p_read_keeps_dav)
    else $error("new data flags changed by a read");

endmodule
`default_nettype wire

// ### test/device_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module device_status_flags_tb
  import status_pkg::*;
;
  localparam int UPD = 4;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        closed_loop;
  logic [11:0] a_adc;
  logic [11:0] b_adc;
  logic [11:0] a_cs;
  logic [11:0] b_cs;
  logic [13:0] upper_alarms;
  logic        conv_done;
  logic [5:0]  dav_set;
  logic        pin_a;
  logic        pin_b;
  logic        amp_n;
  logic        conv_trigger;
  logic        conv_idle;
  int          mismatches;
  int          tests_run;
  int          trig_cnt;
  logic [31:0] dav_exp;

  device_status_flags #(.DW(12), .UPDATE_CYC(UPD)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .closed_loop(closed_loop), .chan_a_adc(a_adc), .chan_b_adc(b_adc),
    .chan_a_cs(a_cs), .chan_b_cs(b_cs), .alarm_low_thresh(12'h100),
    .alarm_high_thresh(12'h800), .upper_alarms(upper_alarms), .conv_done(conv_done),
    .dav_set(dav_set), .standby_pin_a(pin_a), .standby_pin_b(pin_b),
    .amp_enable_pin_n(amp_n), .conv_trigger(conv_trigger), .conv_idle(conv_idle)
  );

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    apb(1'b0, a, 32'h0, d);
    chk(nm, d, exp);
    chk("slverr", {31'h0, pslverr}, 32'h0);
  endtask

  task automatic wait_idle(input string nm);
    int n = 0;
    while (conv_idle !== 1'b1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    chk(nm, {31'h0, conv_idle}, 32'h1);
  endtask

  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // clock, reset, watchdog
  // ****************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (conv_trigger === 1'b1)
      trig_cnt++;

  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    give_verdict;
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {closed_loop, conv_done, dav_set, pin_a, pin_b, upper_alarms} = '0;
    amp_n = 1'b1;
    {a_adc, b_adc, a_cs, b_cs} = {4{12'h400}};
    mismatches = 0;
    tests_run = 0;
    trig_cnt = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(ALARM_STATUS_ADDR, 32'h0, "alarm reset");
    rchk(GENERAL_STATUS_ADDR, 32'h0, "general reset");
    rchk(12'h040, 32'h0, "unmapped");
    // pin mirrors
    pin_a <= 1'b1;
    amp_n <= 1'b0;
    settle();
    rchk(GENERAL_STATUS_ADDR, 32'h6, "pins a amp");
    {pin_a, pin_b, amp_n} <= 3'b011;
    settle();
    rchk(GENERAL_STATUS_ADDR, 32'h8, "pin b");
    pin_b <= 1'b0;
    // direct-mode new data flags, one source at a time
    dav_exp = 32'h0;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge pclk);
      dav_set <= 6'h20 >> i;
      @(posedge pclk);
      dav_set <= 6'h00;
      dav_exp = dav_exp | (32'h2000 >> i) | 32'h8000;
      settle();
      rchk(GENERAL_STATUS_ADDR, dav_exp, "dav flags");
    end
    wr(CONFIG_EVT_ADDR, 32'h2);
    settle();
    rchk(GENERAL_STATUS_ADDR, 32'h0, "dav clear");
    // channel alarms
    closed_loop <= 1'b1;
    a_cs <= 12'h900;
    a_adc <= 12'h800;
    settle();
    rchk(ALARM_STATUS_ADDR, 32'h0, "in window");
    a_adc <= 12'h801;
    settle();
    rchk(ALARM_STATUS_ADDR, 32'h1, "chan a high");
    rchk(GENERAL_STATUS_ADDR, 32'h1, "global set");
    a_adc <= 12'h400;
    settle();
    rchk(GENERAL_STATUS_ADDR, 32'h1, "global sticky");
    rchk(ALARM_STATUS_ADDR, 32'h0, "alarm gone");
    rchk(GENERAL_STATUS_ADDR, 32'h0, "global cleared");
    closed_loop <= 1'b0;
    a_cs <= 12'h400;
    b_cs <= 12'h0ff;
    settle();
    rchk(ALARM_STATUS_ADDR, 32'h2, "chan b low");
    b_cs <= 12'h400;
    upper_alarms <= 14'h2000;
    settle();
    rchk(ALARM_STATUS_ADDR, 32'h8000, "upper alarm");
    upper_alarms <= 14'h0000;
    settle();
    rchk(ALARM_STATUS_ADDR, 32'h0, "upper gone");
    rchk(GENERAL_STATUS_ADDR, 32'h0, "global off");
    // converter readiness
    wr(CONV_CTRL_ADDR, 32'h1);
    repeat (20) @(posedge pclk);
    #1;
    chk("no channel", {31'h0, conv_idle}, 32'h0);
    wr(CONV_CTRL_ADDR, 32'h101);
    wait_idle("ready");
    rchk(GENERAL_STATUS_ADDR, 32'h4000, "ready bit");
    wr(CONFIG_EVT_ADDR, 32'h1);
    @(posedge pclk);
    #1;
    chk("halt", {31'h0, conv_idle}, 32'h0);
    wait_idle("after halt");
    wr(CONV_CTRL_ADDR, 32'h10101);
    for (int n = 0; n < 400 && trig_cnt == 0; n++)
      @(posedge pclk);
    chk("trigger", {31'h0, trig_cnt != 0}, 32'h1);
    rchk(GENERAL_STATUS_ADDR, 32'h0, "running");
    @(posedge pclk);
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
    wait_idle("stopped");
    // status registers ignore writes
    wr(GENERAL_STATUS_ADDR, 32'hffffffff);
    wr(ALARM_STATUS_ADDR, 32'hffffffff);
    rchk(ALARM_STATUS_ADDR, 32'h0, "alarm ro");
    rchk(GENERAL_STATUS_ADDR, 32'h4000, "general ro");
    give_verdict;
  end
endmodule
`default_nettype wire
